// File: rtl/lec_ctrl.sv
// Purpose: Control and interrupt registers of the address lookup engine, with the
//   forwarding, priority, flush and aging decisions they steer.
// Assumes: Event and lookup inputs come from logic on clk_i; registers sit behind classic Wishbone.
// Notes: Every output is a flip-flop, so decisions appear one cycle after their inputs.
//   Register map, one 32-bit word per register, data in bits 7:0 and zero above:
//     0xc44 lookup control one, write-only triggers: bit 5 whole-table flush, bit 4 spanning-tree flush.
//     0xc48 lookup control two: bit 6 trap, bit 5 dynamic filter, bit 4 static filter,
//       bits 3:2 flush selector, bits 1:0 priority source; bit 7 is dropped and reads zero.
//     0xc4c aging period in seconds.
//     0xc50 event status, write one to clear: bit 2 learn fail, bit 1 almost full, bit 0 write fail.
//     0xc54 event mask of the same layout, where a one keeps the event off the interrupt.
//   Bus timing: a request is taken on the edge where cyc and stb are high and ack is low.
//     Ack and read data stand for the one cycle after that edge, and a write lands on the taking edge.
//     A master that keeps stb high after ack is answered again every second cycle, so it must drop it.
//     Writes without byte lane 0 are answered and ignored, since every register sits in that lane.
//   Events: each high cycle of an event input sets its status bit.
//     A set beats a clear written in the same cycle, so an event that races software is never lost.
//     Status latches even while masked, so software can poll with the interrupt switched off.
//   Flush: the triggers are honoured only while the selector is non-zero.
//     flush_done_i returns the selector to zero unless software writes lookup control two in that cycle.
//     The table decides what the scope levels mean; this block only holds and reports them.
//   Forwarding: the trap wins over both egress filters; an untrapped miss passes the address map unchanged.
//   Priority: the higher and lower choices compare the two lookup priorities as unsigned numbers.
//   Aging: age_step_o pulses once per aging period; a period of zero stops the pulses.
//     The second counter runs from reset and a new period acts on the running count,
//     so the first pulse after a change may come early.
//     SEC_CYCLES sets the one-second time base and is shortened for simulation.
//
// Overview of operation
// - With double tagging on and the trap bit set, reserved multicast goes only to the host port.
// - With dynamic filtering set, a dynamic hit forwards to the address map ANDed with the VLAN map.
// - With static filtering set, a static hit forwards to the address map ANDed with the VLAN map.
// - The flush selector picks dynamic only (01), static only (10) or both kinds (11).
// - The flush selector governs both the whole-table flush and the spanning-tree entry flush.
// - A selector of 00 means nothing selected or flush finished, and it resets to 00.
// - The priority field picks destination, source, higher or lower lookup priority.
// - Aging time is the age period register times the entry age count, and the period resets to 0x4b.
// - Status bit 2 latches a learn failure caused by a bucket of static entries until written clear.
// - Status bit 1 latches a static write into a bucket holding two or three valid entries.
// - Status bit 0 latches a write that failed because the bucket was full.
// - The lookup engine summary is the OR of the three status bits.
// - Each event has a mask bit where one disables its interrupt, and all masks reset to one.
// - The whole-table flush trigger starts a selector-limited flush and clears itself.
`timescale 1ns/1ps
module lec_ctrl
  import lec_pkg::*;
#(
  parameter int NPORT = 3,
  parameter int PRIO_W = 3,
  parameter logic [NPORT-1:0] HOST_MAP = 3'h4,
  parameter int SEC_CYCLES = LEC_SEC_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [LEC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic lookup_valid_i,
  input wire logic lookup_hit_i,
  input wire logic lookup_static_i,
  input wire logic reserved_mcast_i,
  input wire logic double_tag_mode_i,
  input wire logic [NPORT-1:0] addr_map_i,
  input wire logic [NPORT-1:0] vlan_map_i,
  input wire logic [PRIO_W-1:0] da_prio_i,
  input wire logic [PRIO_W-1:0] sa_prio_i,
  input wire logic learn_fail_i,
  input wire logic almost_full_i,
  input wire logic write_fail_i,
  input wire logic flush_done_i,
  output logic [NPORT-1:0] fwd_map_o,
  output logic fwd_valid_o,
  output logic [PRIO_W-1:0] address_table_priority_o,
  output logic flush_table_o,
  output logic flush_mstp_o,
  output logic flush_dynamic_o,
  output logic flush_static_o,
  output logic [7:0] aging_period_o,
  output logic age_step_o,
  output logic lookup_engine_summary_o,
  output logic irq_o
);

  localparam int SEC_W = $clog2(SEC_CYCLES + 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);

  typedef struct packed {
    logic [7:0] ctrl_two;
    logic [7:0] aging;
    logic [LEC_EVT_W-1:0] status;
    logic [LEC_EVT_W-1:0] mask;
    logic [SEC_W-1:0] sec_cnt;
    logic [7:0] age_cnt;
    logic ack;
    logic [31:0] rdata;
    logic [NPORT-1:0] fwd_map;
    logic fwd_valid;
    logic [PRIO_W-1:0] prio;
    logic flush_table;
    logic flush_mstp;
    logic age_step;
    logic summary;
    logic irq;
  } lec_state_t;

  lec_state_t st;
  lec_state_t next_st;

  // Word-index match, used by both the read and the write decode.
  function automatic logic idx_hit(input logic [LEC_ADR_W-1:0] adr, input logic [LEC_IDX_W-1:0] idx);
    idx_hit = (adr[LEC_ADR_W-1:LEC_IDX_LSB] == idx);
  endfunction

  function automatic logic [PRIO_W-1:0] pick_prio(input lec_prio_sel_t sel,
                                                  input logic [PRIO_W-1:0] da,
                                                  input logic [PRIO_W-1:0] sa);
    pick_prio = da;
    unique case (sel)
      LEC_PRIO_DA: pick_prio = da;
      LEC_PRIO_SA: pick_prio = sa;
      LEC_PRIO_HIGH: pick_prio = (da > sa) ? da : sa;
      LEC_PRIO_LOW: pick_prio = (da < sa) ? da : sa;
    endcase
  endfunction

  // Bus request and register decode.
  logic req;
  logic rd;
  logic wr;
  logic sel_ctrl_one;
  logic sel_ctrl_two;
  logic sel_aging;
  logic sel_status;
  logic sel_mask;

  // Event latching and interrupt terms.
  logic [LEC_EVT_W-1:0] events;
  logic [LEC_EVT_W-1:0] clr;
  logic [LEC_EVT_W-1:0] pending;

  // Flush selector terms.
  lec_flush_t flush_sel;
  logic flush_allowed;

  // Aging time base terms.
  logic sec_tick;
  logic [7:0] age_next;
  logic age_due;

  // Forwarding and priority terms.
  logic trap_hit;
  logic sta_filter;
  logic dyn_filter;
  logic [NPORT-1:0] filtered_map;
  lec_prio_sel_t prio_sel;

  always_comb begin
    next_st = st;

    // A request is taken only while ack is low, which gives one wait state and a one-cycle ack.
    req = wb_cyc_i && wb_stb_i && !st.ack;
    rd = req && !wb_we_i;
    wr = req && wb_we_i && wb_sel_i[0];
    sel_ctrl_one = idx_hit(wb_adr_i, LEC_IDX_CTRL_ONE);
    sel_ctrl_two = idx_hit(wb_adr_i, LEC_IDX_CTRL_TWO);
    sel_aging = idx_hit(wb_adr_i, LEC_IDX_AGING);
    sel_status = idx_hit(wb_adr_i, LEC_IDX_STATUS);
    sel_mask = idx_hit(wb_adr_i, LEC_IDX_MASK);

    // Bus answer; read data is zero on writes and on unmapped addresses.
    next_st.ack = req;
    next_st.rdata = '0;
    if (rd) begin
      if (sel_ctrl_two) begin
        next_st.rdata[7:0] = st.ctrl_two & LEC_CTRL_TWO_RW;
      end else if (sel_aging) begin
        next_st.rdata[7:0] = st.aging;
      end else if (sel_status) begin
        next_st.rdata[LEC_EVT_W-1:0] = st.status;
      end else if (sel_mask) begin
        next_st.rdata[LEC_EVT_W-1:0] = st.mask;
      end
    end

    // A software write of lookup control two wins over a flush completion in the same cycle.
    flush_sel = lec_flush_t'(st.ctrl_two[LEC_FLUSH_MSB:LEC_FLUSH_LSB]);
    if (wr && sel_ctrl_two) begin
      next_st.ctrl_two = wb_dat_i[7:0] & LEC_CTRL_TWO_RW;
    end else if (flush_done_i) begin
      next_st.ctrl_two[LEC_FLUSH_MSB:LEC_FLUSH_LSB] = LEC_FLUSH_NONE;
    end

    if (wr && sel_aging) begin
      next_st.aging = wb_dat_i[7:0];
    end

    if (wr && sel_mask) begin
      next_st.mask = wb_dat_i[LEC_EVT_W-1:0];
    end

    flush_allowed = (flush_sel != LEC_FLUSH_NONE);
    next_st.flush_table = wr && sel_ctrl_one && flush_allowed && wb_dat_i[LEC_TRIG_ALL_BIT];
    next_st.flush_mstp = wr && sel_ctrl_one && flush_allowed && wb_dat_i[LEC_TRIG_MSTP_BIT];

    // Event inputs gathered in status bit order.
    events = '0;
    events[LEC_EVT_LEARN] = learn_fail_i;
    events[LEC_EVT_FULL] = almost_full_i;
    events[LEC_EVT_WFAIL] = write_fail_i;

    // Write-one-to-clear on the status register.
    clr = '0;
    if (wr && sel_status) begin
      clr = wb_dat_i[LEC_EVT_W-1:0];
    end

    next_st.status = (st.status & ~clr) | events;
    next_st.summary = |next_st.status;
    pending = next_st.status & ~next_st.mask;
    next_st.irq = |pending;

    // one period of the aging sweep
    sec_tick = (st.sec_cnt == SEC_LAST);
    age_next = st.age_cnt + 8'h01;
    age_due = sec_tick && (st.aging != 8'h00) && (age_next >= st.aging);
    if (sec_tick) begin
      next_st.sec_cnt = '0;
    end else begin
      next_st.sec_cnt = st.sec_cnt + SEC_W'(1);
    end
    if (age_due) begin
      next_st.age_cnt = 8'h00;
    end else if (sec_tick) begin
      next_st.age_cnt = age_next;
    end
    next_st.age_step = age_due;

    trap_hit = double_tag_mode_i && reserved_mcast_i && st.ctrl_two[LEC_TRAP_BIT];
    sta_filter = lookup_hit_i && lookup_static_i && st.ctrl_two[LEC_STA_FILT_BIT];
    dyn_filter = lookup_hit_i && !lookup_static_i && st.ctrl_two[LEC_DYN_FILT_BIT];
    filtered_map = addr_map_i & vlan_map_i;
    next_st.fwd_valid = lookup_valid_i;
    if (trap_hit) begin
      next_st.fwd_map = HOST_MAP;
    end else if (sta_filter || dyn_filter) begin
      next_st.fwd_map = filtered_map;
    end else begin
      next_st.fwd_map = addr_map_i;
    end

    prio_sel = lec_prio_sel_t'(st.ctrl_two[LEC_PRIO_MSB:LEC_PRIO_LSB]);
    next_st.prio = pick_prio(prio_sel, da_prio_i, sa_prio_i);

    // Reset overrides every next value, so the outputs show reset values from the first edge.
    if (rst_i) begin
      next_st.ctrl_two = LEC_CTRL_TWO_RST;
      next_st.aging = LEC_AGING_RST;
      next_st.status = '0;
      next_st.mask = LEC_MASK_RST;
      next_st.sec_cnt = '0;
      next_st.age_cnt = '0;
      next_st.ack = 1'b0;
      next_st.rdata = '0;
      next_st.fwd_map = '0;
      next_st.fwd_valid = 1'b0;
      next_st.prio = '0;
      next_st.flush_table = 1'b0;
      next_st.flush_mstp = 1'b0;
      next_st.age_step = 1'b0;
      next_st.summary = 1'b0;
      next_st.irq = 1'b0;
    end
  end

  // The one state register; the synchronous reset is folded into next_st.
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign flush_dynamic_o = st.ctrl_two[LEC_FLUSH_LSB];
  assign flush_static_o = st.ctrl_two[LEC_FLUSH_MSB];
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign fwd_map_o = st.fwd_map;
  assign fwd_valid_o = st.fwd_valid;
  assign address_table_priority_o = st.prio;
  assign flush_table_o = st.flush_table;
  assign flush_mstp_o = st.flush_mstp;
  assign aging_period_o = st.aging;
  assign age_step_o = st.age_step;
  assign lookup_engine_summary_o = st.summary;
  assign irq_o = st.irq;

endmodule

// File: rtl/lec_pkg.sv
// Purpose: Shared constants for the lookup engine control and interrupt block.
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register.
// Notes: Register indices are word numbers; the byte address is four times the index.
package lec_pkg;
  // Register indices and the address window they are decoded from.
  localparam int LEC_ADR_W = 12;
  localparam int LEC_IDX_W = 10;
  localparam logic [9:0] LEC_IDX_CTRL_ONE = 10'h311;
  localparam logic [9:0] LEC_IDX_CTRL_TWO = 10'h312;
  localparam logic [9:0] LEC_IDX_AGING = 10'h313;
  localparam logic [9:0] LEC_IDX_STATUS = 10'h314;
  localparam logic [9:0] LEC_IDX_MASK = 10'h315;
  localparam int LEC_IDX_LSB = 2;

  // Lookup control one: self-clearing flush triggers.
  localparam int LEC_TRIG_ALL_BIT = 5;
  localparam int LEC_TRIG_MSTP_BIT = 4;

  // Lookup control two fields.
  localparam int LEC_TRAP_BIT = 6;
  localparam int LEC_DYN_FILT_BIT = 5;
  localparam int LEC_STA_FILT_BIT = 4;
  localparam int LEC_FLUSH_MSB = 3;
  localparam int LEC_FLUSH_LSB = 2;
  localparam int LEC_PRIO_MSB = 1;
  localparam int LEC_PRIO_LSB = 0;
  localparam logic [7:0] LEC_CTRL_TWO_RW = 8'h7f;
  localparam logic [7:0] LEC_CTRL_TWO_RST = 8'h00;

  // Aging period in seconds.
  localparam logic [7:0] LEC_AGING_RST = 8'h4b;

  // Event bits shared by status and mask.
  localparam int LEC_EVT_W = 3;
  localparam int LEC_EVT_LEARN = 2;
  localparam int LEC_EVT_FULL = 1;
  localparam int LEC_EVT_WFAIL = 0;
  localparam logic [2:0] LEC_MASK_RST = 3'h7;

  // One-second time base.
  localparam longint LEC_SECOND_NS = 1000000000;
  localparam longint LEC_CLK_NS = 10;
  localparam int LEC_SEC_CYCLES = int'(LEC_SECOND_NS / LEC_CLK_NS);

  typedef enum logic [1:0] {
    LEC_FLUSH_NONE = 2'b00,
    LEC_FLUSH_DYN = 2'b01,
    LEC_FLUSH_STA = 2'b10,
    LEC_FLUSH_BOTH = 2'b11
  } lec_flush_t;

  typedef enum logic [1:0] {
    LEC_PRIO_DA = 2'b00,
    LEC_PRIO_SA = 2'b01,
    LEC_PRIO_HIGH = 2'b10,
    LEC_PRIO_LOW = 2'b11
  } lec_prio_sel_t;
endpackage

// File: bench/lec_ctrl_chk.sv
// Purpose: Port-level assertions for the lookup engine control block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Status and selector are internal, so checks lean on the summary and flush levels.
`timescale 1ns/1ps
module lec_ctrl_chk #(
  parameter int NPORT = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic lookup_valid_i,
  input wire logic reserved_mcast_i,
  input wire logic [NPORT-1:0] addr_map_i,
  input wire logic learn_fail_i,
  input wire logic almost_full_i,
  input wire logic write_fail_i,
  input wire logic [NPORT-1:0] fwd_map_o,
  input wire logic fwd_valid_o,
  input wire logic flush_table_o,
  input wire logic flush_dynamic_o,
  input wire logic flush_static_o,
  input wire logic age_step_o,
  input wire logic lookup_engine_summary_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_drops: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  a_learn_sets: assert property (learn_fail_i |=> lookup_engine_summary_o) else $error("learn lost");
  a_full_sets: assert property (almost_full_i |=> lookup_engine_summary_o) else $error("full lost");
  a_wfail_sets: assert property (write_fail_i |=> lookup_engine_summary_o) else $error("wfail lost");
  a_irq_needs_status: assert property (irq_o |-> lookup_engine_summary_o) else $error("irq alone");
  a_fwd_echo: assert property (lookup_valid_i |=> fwd_valid_o) else $error("no fwd valid");
  a_fwd_subset: assert property (
    fwd_valid_o && !$past(reserved_mcast_i) |-> (fwd_map_o & ~$past(addr_map_i)) == '0)
    else $error("fwd beyond map");
  a_flush_needs_sel: assert property (flush_table_o |-> $past(flush_dynamic_o || flush_static_o))
    else $error("flush unselected");
  a_flush_pulse: assert property (flush_table_o |=> !flush_table_o) else $error("flush stuck");
  cover property (irq_o);
  cover property (flush_table_o);
  cover property (age_step_o);
endmodule

bind lec_ctrl lec_ctrl_chk #(.NPORT(NPORT)) u_lec_ctrl_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .lookup_valid_i(lookup_valid_i),
  .reserved_mcast_i(reserved_mcast_i),
  .addr_map_i(addr_map_i),
  .learn_fail_i(learn_fail_i),
  .almost_full_i(almost_full_i),
  .write_fail_i(write_fail_i),
  .fwd_map_o(fwd_map_o),
  .fwd_valid_o(fwd_valid_o),
  .flush_table_o(flush_table_o),
  .flush_dynamic_o(flush_dynamic_o),
  .flush_static_o(flush_static_o),
  .age_step_o(age_step_o),
  .lookup_engine_summary_o(lookup_engine_summary_o),
  .irq_o(irq_o)
);

// File: bench/lec_ctrl_test.sv
// Purpose: Register and behaviour test of the lookup engine control block.
// Assumes: The one-second time base is shortened to 10 cycles.
// Notes: Every wait is bounded; a run-out counts as a mismatch.
`timescale 1ns/1ps
module lec_ctrl_test;
  import lec_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [11:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic lookup_valid_i = 0, lookup_hit_i = 0, lookup_static_i = 0, reserved_mcast_i = 0, double_tag_mode_i = 1;
  logic learn_fail_i = 0, almost_full_i = 0, write_fail_i = 0, flush_done_i = 0;
  logic [2:0] addr_map_i = '0, vlan_map_i = '0, da_prio_i = '0, sa_prio_i = '0, fwd_map_o, address_table_priority_o;
  logic fwd_valid_o, flush_table_o, flush_mstp_o, flush_dynamic_o, flush_static_o, age_step_o, lookup_engine_summary_o;
  logic irq_o;
  logic [7:0] aging_period_o;
  int fail_count = 0, n_checks = 0, gap, base_tbl, base_mstp;
  int np [2];
  always #5 clk_i = ~clk_i;
  lec_ctrl #(.SEC_CYCLES(10)) u_lec_ctrl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .lookup_valid_i(lookup_valid_i),
    .lookup_hit_i(lookup_hit_i),
    .lookup_static_i(lookup_static_i),
    .reserved_mcast_i(reserved_mcast_i),
    .double_tag_mode_i(double_tag_mode_i),
    .addr_map_i(addr_map_i),
    .vlan_map_i(vlan_map_i),
    .da_prio_i(da_prio_i),
    .sa_prio_i(sa_prio_i),
    .learn_fail_i(learn_fail_i),
    .almost_full_i(almost_full_i),
    .write_fail_i(write_fail_i),
    .flush_done_i(flush_done_i),
    .fwd_map_o(fwd_map_o),
    .fwd_valid_o(fwd_valid_o),
    .address_table_priority_o(address_table_priority_o),
    .flush_table_o(flush_table_o),
    .flush_mstp_o(flush_mstp_o),
    .flush_dynamic_o(flush_dynamic_o),
    .flush_static_o(flush_static_o),
    .aging_period_o(aging_period_o),
    .age_step_o(age_step_o),
    .lookup_engine_summary_o(lookup_engine_summary_o),
    .irq_o(irq_o)
  );
  // Pulses are counted on every edge so the check does not depend on their exact cycle.
  always @(posedge clk_i) begin
    np[0] += flush_table_o;
    np[1] += flush_mstp_o;
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bus(logic we, logic [11:0] a, logic [31:0] d);
    int n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      final_report();
    end
    @(posedge clk_i);
  endtask
  task automatic rdc(string s, logic [11:0] a, logic [31:0] e);
    bus(0, a, 32'h0);
    chk(s, e, q);
  endtask
  task automatic ev(int i);
    {learn_fail_i, almost_full_i, write_fail_i} <= 3'h4 >> i;
    @(posedge clk_i);
    {learn_fail_i, almost_full_i, write_fail_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  task automatic lk(logic [7:0] c, logic st, logic rm, logic h, logic [2:0] em, logic [2:0] ep);
    bus(1, 12'hc48, {24'h0, c});
    lookup_valid_i <= 1;
    lookup_hit_i <= h;
    lookup_static_i <= st;
    reserved_mcast_i <= rm;
    addr_map_i <= 3'h7;
    vlan_map_i <= 3'h2;
    da_prio_i <= 3'h5;
    sa_prio_i <= 3'h2;
    @(posedge clk_i);
    lookup_valid_i <= 0;
    @(posedge clk_i);
    chk("fwd valid", 1, fwd_valid_o);
    chk("fwd map", em, fwd_map_o);
    chk("priority", ep, address_table_priority_o);
  endtask
  task automatic step(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (age_step_o !== 1'b1 && k < 100);
    if (age_step_o !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    rdc("ctrl two", 12'hc48, 32'h0);
    rdc("aging", 12'hc4c, 32'h4b);
    rdc("status", 12'hc50, 32'h0);
    rdc("mask", 12'hc54, 32'h7);
    rdc("unmapped", 12'hc00, 32'h0);
    bus(1, 12'hc48, 32'hffffffff);
    rdc("ctrl two rsvd", 12'hc48, 32'h7f);
    for (int i = 0; i < 3; i++) begin
      ev(i);
      rdc("status", 12'hc50, 32'h4 >> i);
      chk("summary", 1, lookup_engine_summary_o);
      chk("irq masked", 0, irq_o);
      bus(1, 12'hc54, 32'h7 ^ (32'h4 >> i));
      chk("irq", 1, irq_o);
      bus(1, 12'hc50, 32'h4 >> i);
      chk("irq cleared", 0, irq_o);
      rdc("status clear", 12'hc50, 32'h0);
      chk("summary cleared", 0, lookup_engine_summary_o);
      bus(1, 12'hc54, 32'h7);
    end
    for (int s = 0; s < 4; s++) begin
      bus(1, 12'hc48, s << 2);
      chk("flush dyn", s & 1, flush_dynamic_o);
      chk("flush sta", s >> 1, flush_static_o);
      base_tbl = np[0];
      base_mstp = np[1];
      bus(1, 12'hc44, 32'h30);
      repeat (3) @(posedge clk_i);
      chk("table pulses", s != 0, np[0] - base_tbl);
      chk("mstp pulses", s != 0, np[1] - base_mstp);
    end
    flush_done_i <= 1;
    @(posedge clk_i);
    flush_done_i <= 0;
    rdc("flush done", 12'hc48, 32'h0);
    lk(8'h20, 0, 0, 1, 3'h2, 3'h5);
    lk(8'h00, 0, 0, 1, 3'h7, 3'h5);
    lk(8'h11, 1, 0, 1, 3'h2, 3'h2);
    lk(8'h22, 1, 0, 1, 3'h7, 3'h5);
    lk(8'h13, 1, 0, 1, 3'h2, 3'h2);
    lk(8'h30, 0, 0, 1, 3'h2, 3'h5);
    lk(8'h30, 1, 0, 0, 3'h7, 3'h5);
    lk(8'h40, 0, 1, 1, 3'h4, 3'h5);
    lk(8'h00, 0, 1, 1, 3'h7, 3'h5);
    double_tag_mode_i <= 0;
    lk(8'h40, 0, 1, 1, 3'h7, 3'h5);
    bus(1, 12'hc4c, 32'h2);
    chk("aging out", 8'h2, aging_period_o);
    step(gap);
    step(gap);
    step(gap);
    chk("age interval", 20, gap);
    final_report();
  end
endmodule
